// ### hdl/cs_pkg.sv
// Package for the chip-select and wait-state decoder.
// Assumes a single 250 MHz clock and a processor bus whose cycles start
// with a one-cycle request.
package cs_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int WAIT_STATE_NS = 25;
	localparam int STROBE_BASE_NS = 100;
	localparam int TICK_CYC = (WAIT_STATE_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int BASE_TICKS = STROBE_BASE_NS / WAIT_STATE_NS;
	localparam int PRE_W = 3;
	localparam logic [PRE_W-1:0] TICK_LAST = PRE_W'(TICK_CYC - 1);

	typedef logic [4:0] ticks_t;

	// ------------------------------------------------------------------
	// Register offsets in I/O space
	// ------------------------------------------------------------------
	localparam logic [15:0] UPPER_CFG_ADDR = 16'hFFA0;
	localparam logic [15:0] LOWER_CFG_ADDR = 16'hFFA2;
	localparam logic [15:0] PBASE_CFG_ADDR = 16'hFFA4;
	localparam logic [15:0] MID_MEM_CFG_ADDR = 16'hFFA6;
	localparam logic [15:0] MID_PER_CFG_ADDR = 16'hFFA8;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] UPPER_CFG_RST = 16'h80BF;
	localparam logic [15:0] LOWER_CFG_RST = 16'h7FBF;
	localparam logic [15:0] PBASE_CFG_RST = 16'h007F;
	localparam logic [15:0] MID_MEM_CFG_RST = 16'h81FF;
	localparam logic [15:0] MID_PER_CFG_RST = 16'hA0BF;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int WAIT_MSB = 1;
	localparam int IGN_RDY_BIT = 2;
	localparam int PWAIT_MSB = 2;
	localparam int PSEUDO_STATIC_REFRESH_BIT = 6;
	localparam int PCS_MODE_BIT = 7;
	localparam int BLK_LSB = 8;
	localparam int BLK_MSB = 13;
	localparam int UP_EN_BIT = 15;
	localparam int MID_BASE_LSB = 9;
	localparam int MID_BASE_MSB = 15;
	localparam int MID_SIZE_LSB = 8;
	localparam int MID_SIZE_MSB = 14;
	localparam int PBASE_LSB = 8;
	localparam int PBASE_MSB = 15;
	localparam int LOW_PCS_N = 4;
	localparam logic [7:0] UPCS_PAGE0 = 8'h05;
	localparam logic [7:0] UPCS_PAGE1 = 8'h06;

	// Peripheral wait selector to inserted wait states
	function automatic logic [3:0] pcs_waits(input logic [2:0] sel);
		logic [3:0] w;
		w = 4'h0;
		unique case (sel)
			3'h0: w = 4'h0;
			3'h1: w = 4'h1;
			3'h2: w = 4'h2;
			3'h3: w = 4'h3;
			3'h4: w = 4'h5;
			3'h5: w = 4'h7;
			3'h6: w = 4'h9;
			3'h7: w = 4'hF;
		endcase
		return w;
	endfunction

endpackage

// ### hdl/cs_timer_if.sv
// Link between the decoder and its strobe timer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface cs_timer_if;
	logic load;
	cs_pkg::ticks_t ticks;
	logic ign_rdy;
	logic active;
	logic done;
	modport ctl(output load, output ticks, output ign_rdy,
		input active, input done);
	modport tmr(input load, input ticks, input ign_rdy,
		output active, output done);
endinterface

// ### hdl/cs_wait_timer.sv
// Strobe timer: holds a bus cycle for a number of 28 ns ticks.
// Assumes load comes only while the timer is idle.
`timescale 1ns/10ps
module cs_wait_timer (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic rdy_i,
	cs_timer_if.tmr t
);
	logic [cs_pkg::PRE_W-1:0] pre_r;
	cs_pkg::ticks_t ticks_r;
	logic active_r;
	logic expired_r;
	logic ign_r;
	logic tick;
	logic last;

	// ------------------------------------------------------------------
	// Tick divider and countdown
	// ------------------------------------------------------------------
	// One-cycle enable every wait-state period
	assign tick = active_r && (pre_r == cs_pkg::TICK_LAST);
	assign last = expired_r || (tick && ticks_r == 5'h01);
	assign t.done = active_r && last && (ign_r || rdy_i);
	assign t.active = active_r;

	// Divider restarts with each cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || t.load || tick) begin
			pre_r <= '0;
		end else if (active_r) begin
			pre_r <= pre_r + 3'h1;
		end
	end

	// Remaining ticks of the strobe
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ticks_r <= '0;
		end else if (t.load) begin
			ticks_r <= t.ticks;
		end else if (tick && ticks_r != 5'h01) begin
			ticks_r <= ticks_r - 5'h01;
		end
	end

	// Busy state and stretch on external ready
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			active_r <= 1'b0;
			expired_r <= 1'b0;
			ign_r <= 1'b1;
		end else if (t.load) begin
			active_r <= 1'b1;
			expired_r <= 1'b0;
			ign_r <= t.ign_rdy;
		end else if (t.done) begin
			active_r <= 1'b0;
			expired_r <= 1'b0;
		end else if (last) begin
			expired_r <= 1'b1;
		end
	end
endmodule

// ### hdl/chip_select_wait_decoder.sv
// Chip-select decoder with programmable wait states.
// Assumes a processor bus that raises cyc_i for one cycle per access,
// with address, space and write data valid in that cycle.
//
// What this block does
// - Upper select for memory in upper half of 1 MB, one 512K block.
// - Upper region gets three wait states after reset.
// - Lower select from address zero up to 512K, three waits by default.
// - Lower region runs without refresh and without waiting on ready.
// - Mid select covers 256K from the midpoint, overlapping upper region.
// - Upper two peripheral selects are chip selects with three waits.
// - Lowest four peripheral selects get fifteen waits by default.
// - Peripheral selects start at I/O zero, one per 0x100 page: pages 0 to 3, then 5 and 6.
// - Peripheral wait code 0..7 gives 0,1,2,3,5,7,9,15 waits.
// - I/O strobe lasts 112 ns plus 28 ns per wait state.
// - Wait states count in 28 ns periods (25 ns rounded up to 7 clocks).
`timescale 1ns/10ps
module chip_select_wait_decoder (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic cyc_i,
	input wire logic mem_i,
	input wire logic wr_i,
	input wire logic [19:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic rdy_i,
	output logic [15:0] rdata_o,
	output logic busy_o,
	output logic done_o,
	output logic upper_memory_select_n_o,
	output logic lower_region_select_n_o,
	output logic first_mid_memory_select_n_o,
	output logic [3:0] low_peripheral_selects_n_o,
	output logic [1:0] upper_peripheral_selects_n_o,
	output logic io_enable_n_o
);
	cs_timer_if t();
	logic [15:0] upper_cfg_r;
	logic [15:0] lower_cfg_r;
	logic [15:0] pbase_cfg_r;
	logic [15:0] mid_mem_cfg_r;
	logic [15:0] mid_per_cfg_r;
	logic acc;
	logic reg_hit;
	logic up_hit;
	logic lo_hit;
	logic mid_hit;
	logic per_io;
	logic [3:0] lpcs_hit;
	logic [1:0] upcs_hit;
	logic [6:0] mid_off;
	logic [7:0] page_off;
	logic [3:0] waits_nxt;
	logic ign_nxt;
	logic up_r;
	logic lo_r;
	logic mid_r;
	logic [3:0] lpcs_r;
	logic [1:0] upcs_r;
	logic io_r;
	logic [15:0] rdata_r;
	logic [3:0] cur_waits_r;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	assign acc = cyc_i && !t.active;
	assign reg_hit = !mem_i && (addr_i[15:0] == cs_pkg::UPPER_CFG_ADDR ||
		addr_i[15:0] == cs_pkg::LOWER_CFG_ADDR ||
		addr_i[15:0] == cs_pkg::PBASE_CFG_ADDR ||
		addr_i[15:0] == cs_pkg::MID_MEM_CFG_ADDR ||
		addr_i[15:0] == cs_pkg::MID_PER_CFG_ADDR);
	// Upper block opens at its programmed base in the top half
	assign up_hit = mem_i && upper_cfg_r[cs_pkg::UP_EN_BIT] && addr_i[19] &&
		addr_i[18:13] >= upper_cfg_r[cs_pkg::BLK_MSB:cs_pkg::BLK_LSB];
	assign lo_hit = mem_i && !addr_i[19] &&
		addr_i[18:13] <= lower_cfg_r[cs_pkg::BLK_MSB:cs_pkg::BLK_LSB];
	// Window measured in 8K blocks from its base
	assign mid_off = addr_i[19:13] -
		mid_mem_cfg_r[cs_pkg::MID_BASE_MSB:cs_pkg::MID_BASE_LSB];
	assign mid_hit = mem_i &&
		mid_off < mid_per_cfg_r[cs_pkg::MID_SIZE_MSB:cs_pkg::MID_SIZE_LSB];
	// One 256-byte page per peripheral select
	assign per_io = !mem_i && !reg_hit;
	assign page_off = addr_i[15:8] -
		pbase_cfg_r[cs_pkg::PBASE_MSB:cs_pkg::PBASE_LSB];

	// Peripheral select decode, one per page
	genvar gi;
	generate
		for (gi = 0; gi < cs_pkg::LOW_PCS_N; gi++) begin : g_lpcs
			assign lpcs_hit[gi] = per_io && page_off == 8'(gi);
		end
	endgenerate
	assign upcs_hit[0] = per_io && page_off == cs_pkg::UPCS_PAGE0 &&
		mid_per_cfg_r[cs_pkg::PCS_MODE_BIT];
	assign upcs_hit[1] = per_io && page_off == cs_pkg::UPCS_PAGE1 &&
		mid_per_cfg_r[cs_pkg::PCS_MODE_BIT];

	// Wait states and ready use; the mid window wins over the upper block
	always_comb begin
		waits_nxt = 4'h0;
		ign_nxt = 1'b1;
		if (mid_hit) begin
			waits_nxt = {2'b00, mid_mem_cfg_r[cs_pkg::WAIT_MSB:0]};
			ign_nxt = mid_mem_cfg_r[cs_pkg::IGN_RDY_BIT];
		end else if (up_hit) begin
			waits_nxt = {2'b00, upper_cfg_r[cs_pkg::WAIT_MSB:0]};
			ign_nxt = upper_cfg_r[cs_pkg::IGN_RDY_BIT];
		end else if (lo_hit) begin
			waits_nxt = {2'b00, lower_cfg_r[cs_pkg::WAIT_MSB:0]};
			ign_nxt = lower_cfg_r[cs_pkg::IGN_RDY_BIT];
		end else if (|lpcs_hit) begin
			waits_nxt = cs_pkg::pcs_waits(
				pbase_cfg_r[cs_pkg::PWAIT_MSB:0]);
			ign_nxt = mid_per_cfg_r[cs_pkg::IGN_RDY_BIT];
		end else if (|upcs_hit) begin
			waits_nxt = {2'b00, mid_per_cfg_r[cs_pkg::WAIT_MSB:0]};
			ign_nxt = mid_per_cfg_r[cs_pkg::IGN_RDY_BIT];
		end
	end

	// Strobe of four 28 ns ticks (112 ns) plus one tick per wait state
	assign t.load = acc;
	assign t.ticks = 5'(cs_pkg::BASE_TICKS) + {1'b0, waits_nxt};
	assign t.ign_rdy = ign_nxt;

	cs_wait_timer u_timer (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.rdy_i(rdy_i),
		.t(t)
	);

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	// Written at the accepted cycle, so the next cycle decodes with them
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			upper_cfg_r <= cs_pkg::UPPER_CFG_RST;
			lower_cfg_r <= cs_pkg::LOWER_CFG_RST;
			pbase_cfg_r <= cs_pkg::PBASE_CFG_RST;
			mid_mem_cfg_r <= cs_pkg::MID_MEM_CFG_RST;
			mid_per_cfg_r <= cs_pkg::MID_PER_CFG_RST;
		end else if (acc && reg_hit && wr_i) begin
			unique case (addr_i[15:0])
				cs_pkg::UPPER_CFG_ADDR: upper_cfg_r <= wdata_i;
				cs_pkg::LOWER_CFG_ADDR: lower_cfg_r <= wdata_i;
				cs_pkg::PBASE_CFG_ADDR: pbase_cfg_r <= wdata_i;
				cs_pkg::MID_MEM_CFG_ADDR: mid_mem_cfg_r <= wdata_i;
				cs_pkg::MID_PER_CFG_ADDR: mid_per_cfg_r <= wdata_i;
				default: upper_cfg_r <= upper_cfg_r;
			endcase
		end
	end

	// Register read data, captured at the accepted read
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_r <= '0;
		end else if (acc && reg_hit && !wr_i) begin
			unique case (addr_i[15:0])
				cs_pkg::UPPER_CFG_ADDR: rdata_r <= upper_cfg_r;
				cs_pkg::LOWER_CFG_ADDR: rdata_r <= lower_cfg_r;
				cs_pkg::PBASE_CFG_ADDR: rdata_r <= pbase_cfg_r;
				cs_pkg::MID_MEM_CFG_ADDR: rdata_r <= mid_mem_cfg_r;
				cs_pkg::MID_PER_CFG_ADDR: rdata_r <= mid_per_cfg_r;
				default: rdata_r <= '0;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Select outputs
	// ------------------------------------------------------------------
	// Set at acceptance, released on the cycle that ends the strobe
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || t.done) begin
			up_r <= 1'b0;
			lo_r <= 1'b0;
			mid_r <= 1'b0;
			lpcs_r <= '0;
			upcs_r <= '0;
			io_r <= 1'b0;
		end else if (acc) begin
			up_r <= up_hit;
			lo_r <= lo_hit;
			mid_r <= mid_hit;
			lpcs_r <= lpcs_hit;
			upcs_r <= upcs_hit;
			io_r <= (|lpcs_hit) || (|upcs_hit);
		end
	end

	// Wait states of the running cycle, kept for status
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cur_waits_r <= '0;
		end else if (acc) begin
			cur_waits_r <= waits_nxt;
		end
	end

	assign upper_memory_select_n_o = !up_r;
	assign lower_region_select_n_o = !lo_r;
	assign first_mid_memory_select_n_o = !mid_r;
	assign low_peripheral_selects_n_o = ~lpcs_r;
	assign upper_peripheral_selects_n_o = ~upcs_r;
	assign io_enable_n_o = !io_r;
	assign rdata_o = rdata_r;
	assign busy_o = t.active;
	assign done_o = t.done;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	localparam int LOWER_MAX_CYC = (cs_pkg::BASE_TICKS + 3) *
		cs_pkg::TICK_CYC;
	logic [7:0] len_r;
	logic [7:0] exp_len_r;
	logic exp_ign_r;

	// Strobe length measured against the loaded tick count
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || io_r == 1'b0) begin
			len_r <= '0;
		end else begin
			len_r <= len_r + 8'h01;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			exp_len_r <= '0;
			exp_ign_r <= 1'b1;
		end else if (acc) begin
			exp_len_r <= 8'(t.ticks * cs_pkg::TICK_CYC);
			exp_ign_r <= ign_nxt;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_acc_mem;
		acc && mem_i;
	endsequence
	sequence s_acc_io;
		acc && !mem_i && !reg_hit;
	endsequence

	property p_upper_sel;
		s_acc_mem ##0 (upper_cfg_r[15] && addr_i[19] && addr_i[18:13] >=
			upper_cfg_r[13:8]) |=> !upper_memory_select_n_o;
	endproperty
	a_upper_sel: assert property (p_upper_sel)
		else $error("upper select missing");

	property p_lower_sel;
		s_acc_mem ##0 (!addr_i[19] && addr_i[18:13] <= lower_cfg_r[13:8])
			|=> !lower_region_select_n_o && upper_memory_select_n_o;
	endproperty
	a_lower_sel: assert property (p_lower_sel)
		else $error("lower select missing");

	property p_mid_sel;
		s_acc_mem ##0 (addr_i[19:13] - mid_mem_cfg_r[15:9] <
			mid_per_cfg_r[14:8]) |=> !first_mid_memory_select_n_o;
	endproperty
	a_mid_sel: assert property (p_mid_sel)
		else $error("mid select missing");

	property p_pcs_page;
		s_acc_io ##0 (page_off < 8'h04) |=>
			low_peripheral_selects_n_o == ~(4'h1 << $past(page_off[1:0]));
	endproperty
	a_pcs_page: assert property (p_pcs_page)
		else $error("wrong peripheral select");

	property p_upper_pcs;
		s_acc_io ##0 (|upcs_hit) |=> upper_peripheral_selects_n_o != 2'b11
			&& cur_waits_r == {2'b00, $past(mid_per_cfg_r[1:0])};
	endproperty
	a_upper_pcs: assert property (p_upper_pcs)
		else $error("upper peripheral select or waits wrong");

	property p_low_waits;
		s_acc_io ##0 (|lpcs_hit) |=>
			cur_waits_r == cs_pkg::pcs_waits($past(pbase_cfg_r[2:0]));
	endproperty
	a_low_waits: assert property (p_low_waits)
		else $error("low peripheral waits wrong");

	property p_strobe_len;
		$rose(io_enable_n_o) && exp_ign_r |-> $past(len_r) + 8'h01 ==
			exp_len_r;
	endproperty
	a_strobe_len: assert property (p_strobe_len)
		else $error("io strobe length wrong");

	property p_release;
		!busy_o |-> upper_memory_select_n_o && lower_region_select_n_o &&
			first_mid_memory_select_n_o && io_enable_n_o &&
			(&low_peripheral_selects_n_o) &&
			(&upper_peripheral_selects_n_o);
	endproperty
	a_release: assert property (p_release)
		else $error("select active outside a cycle");

	property p_lower_noready;
		s_acc_mem ##0 (lo_hit && !mid_hit && lower_cfg_r[2])
			|-> ##[1:LOWER_MAX_CYC] done_o;
	endproperty
	a_lower_noready: assert property (p_lower_noready)
		else $error("lower cycle waited on ready");

	property p_cfg_next;
		acc && reg_hit && wr_i && addr_i[15:0] == cs_pkg::UPPER_CFG_ADDR |=>
			upper_cfg_r == $past(wdata_i);
	endproperty
	a_cfg_next: assert property (p_cfg_next)
		else $error("config write not applied");
endmodule

// ### sim/cs_far_side_model.sv
// Far-side model: memory and peripheral chips answering with ready.
// Assumes active-low selects from the decoder and a delay set by the bench.
`timescale 1ns/10ps
module cs_far_side_model (
	input wire logic clk_i,
	input wire logic [9:0] sel_n_i,
	input wire logic [7:0] delay_i,
	output logic rdy_o
);
	logic [7:0] cnt_r = 8'h00;
	logic tog_r = 1'b0;

	// ------------------------------------------------------------------
	// Ready timing
	// ------------------------------------------------------------------
	// Count cycles since a select went low; idle line keeps changing
	always_ff @(posedge clk_i) begin
		tog_r <= ~tog_r;
		if (&sel_n_i) begin
			cnt_r <= 8'h00;
		end else if (cnt_r != 8'hFF) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	// Ready after the set delay; no stale level while deselected
	assign rdy_o = (&sel_n_i) ? tog_r : (cnt_r >= delay_i);
endmodule

// ### sim/chip_select_wait_decoder_tb_top.sv
// Testbench for the chip-select and wait-state decoder.
// Assumes the design package, interface, modules and far-side model.
`timescale 1ns/10ps
module chip_select_wait_decoder_tb_top;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	typedef struct {
		int n;
		logic [9:0] sel;
		logic chk;
		logic [15:0] rd;
	} note_t;
	localparam logic [9:0] sel_up = 10'h200;
	localparam logic [9:0] sel_lo = 10'h100;
	localparam logic [9:0] sel_mid = 10'h080;
	localparam logic [9:0] sel_p5 = 10'h002;
	localparam logic [9:0] sel_p6 = 10'h004;
	localparam logic [9:0] sel_io = 10'h001;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cyc_i = 1'b0;
	logic mem_i = 1'b0;
	logic wr_i = 1'b0;
	logic [19:0] addr_i = 20'h00000;
	logic [15:0] wdata_i = 16'h0000;
	logic [7:0] delay = 8'h00;
	logic rdy_i, busy_o, done_o, um_n, lr_n, mm_n, io_n;
	logic [15:0] rdata_o;
	logic [3:0] lp_n;
	logic [1:0] up_n;
	logic [9:0] sel_now;
	logic rel = 1'b0;
	note_t notes[$];
	note_t nt;
	int err_count = 0;
	int total_checks = 0;
	int cnt = 0;
	int n_of[8] = '{0, 1, 2, 3, 5, 7, 9, 15};

	assign sel_now = {um_n, lr_n, mm_n, lp_n, up_n, io_n};
	always #2 clk_i = ~clk_i;

	chip_select_wait_decoder chip_select_wait_decoder_i (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc_i), .mem_i(mem_i),
		.wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdy_i(rdy_i),
		.rdata_o(rdata_o), .busy_o(busy_o), .done_o(done_o),
		.upper_memory_select_n_o(um_n), .lower_region_select_n_o(lr_n),
		.first_mid_memory_select_n_o(mm_n),
		.low_peripheral_selects_n_o(lp_n),
		.upper_peripheral_selects_n_o(up_n), .io_enable_n_o(io_n));

	cs_far_side_model cs_far_side_model_i (
		.clk_i(clk_i), .sel_n_i(sel_now), .delay_i(delay), .rdy_o(rdy_i));

	// ------------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time,
				seen, exp);
		end
	endtask

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Monitor: time each strobe and compare against the oldest note
	always @(negedge clk_i) begin
		if (rel) begin
			check(sel_now, 10'h3FF);
			rel = 1'b0;
		end
		if (busy_o === 1'b1) cnt++;
		if (cnt == 1 && notes.size() > 0) check(sel_now, notes[0].sel);
		if (done_o === 1'b1) begin
			if (notes.size() == 0) begin
				check(32'h0, 32'h1);
			end else begin
				nt = notes.pop_front();
				check(cnt, nt.n);
				check(sel_now, nt.sel);
				if (nt.chk) check(rdata_o, nt.rd);
			end
			cnt = 0;
			rel = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Bus driver
	// ------------------------------------------------------------------
	// One bus cycle; poke raises a second request while busy
	task automatic bus(input logic m, input logic w, input logic [19:0] a,
		input logic [15:0] d, input int n, input logic [9:0] clr,
		input logic chk, input logic [15:0] rd, input logic poke);
		note_t e;
		int k;
		e.n = n;
		e.sel = 10'h3FF & ~clr;
		e.chk = chk;
		e.rd = rd;
		@(negedge clk_i);
		notes.push_back(e);
		cyc_i = 1'b1;
		mem_i = m;
		wr_i = w;
		addr_i = a;
		wdata_i = d;
		@(negedge clk_i);
		k = 0;
		while (done_o !== 1'b1 && k < 400) begin
			cyc_i = (poke && k == 3);
			@(negedge clk_i);
			k++;
		end
		cyc_i = 1'b0;
		if (k >= 400) check(32'h0, 32'h1);
	endtask

	task automatic reg_rd(input logic [15:0] a, input logic [15:0] e);
		bus(1'b0, 1'b0, {4'h0, a}, 16'h0000, 28, 10'h000, 1'b1, e, 1'b0);
	endtask

	task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
		bus(1'b0, 1'b1, {4'h0, a}, d, 28, 10'h000, 1'b0, 16'h0000, 1'b0);
	endtask

	task automatic mem(input logic [19:0] a, input int n,
		input logic [9:0] c);
		bus(1'b1, 1'b0, a, 16'h0000, n, c, 1'b0, 16'h0000, 1'b0);
	endtask

	task automatic io(input logic [19:0] a, input int n,
		input logic [9:0] c);
		bus(1'b0, 1'b0, a, 16'h0000, n, c, 1'b0, 16'h0000, 1'b0);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		int p;
		void'($urandom(32'h7011));
		repeat (4) @(negedge clk_i);
		rst_n_i = 1'b1;
		// Register values after reset
		reg_rd(16'hFFA0, 16'h80BF);
		reg_rd(16'hFFA2, 16'h7FBF);
		reg_rd(16'hFFA4, 16'h007F);
		reg_rd(16'hFFA6, 16'h81FF);
		reg_rd(16'hFFA8, 16'hA0BF);
		// Memory regions and their edges, slow ready on the lower one
		mem(20'h00000, 49, sel_lo);
		delay = 8'd100;
		mem(20'h7FFFE, 49, sel_lo);
		delay = 8'd0;
		mem(20'h80000, 49, sel_up | sel_mid);
		mem(20'hBFFFE, 49, sel_up | sel_mid);
		mem(20'hC0000, 49, sel_up);
		mem(20'hFFFFE, 49, sel_up);
		// Peripheral pages at default waits
		for (int i = 0; i < 4; i++) begin
			io({4'h0, 8'(i), 8'($urandom)}, 133,
				(10'h008 << i) | sel_io);
		end
		io({12'h005, 8'($urandom)}, 49, sel_p5 | sel_io);
		io({12'h006, 8'($urandom)}, 49, sel_p6 | sel_io);
		io(20'h00800, 28, 10'h000);
		// Second request while busy is ignored
		bus(1'b0, 1'b0, 20'h00100, 16'h0000, 133, 10'h010 | sel_io, 1'b0,
			16'h0000, 1'b1);
		// Moved peripheral base takes effect on the next cycle
		reg_wr(16'hFFA4, 16'h107F);
		io(20'h01000, 133, 10'h008 | sel_io);
		io(20'h01300, 133, 10'h040 | sel_io);
		// Every peripheral wait code
		for (int c = 0; c < 8; c++) begin
			reg_wr(16'hFFA4, 16'h0078 | 16'(c));
			p = $urandom_range(3);
			io({4'h0, 8'(p), 8'($urandom)}, (4 + n_of[c]) * 7,
				(10'h008 << p) | sel_io);
		end
		// Upper region at zero waits
		reg_wr(16'hFFA0, 16'h80BC);
		mem(20'hFFFFE, 28, sel_up);
		// Upper peripherals waiting on ready, slow then prompt
		reg_wr(16'hFFA8, 16'hA0BB);
		delay = 8'd60;
		io(20'h00500, 61, sel_p5 | sel_io);
		delay = 8'd0;
		io(20'h00600, 49, sel_p6 | sel_io);
		repeat (4) @(negedge clk_i);
		check(notes.size(), 0);
		final_report();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (30000) @(posedge clk_i);
		err_count++;
		final_report();
	end
endmodule
